// *** hw/fgp_regs.sv ***
`timescale 1ns/1ps
// Overview of operation
// [RULE_01] resistance code times 32 milliohm, 8 bits
// [RULE_02] six resistance registers, reset 0x3f each
// [RULE_03] low charge coefficient bits 5:4, reset 00
// [RULE_04] charging coefficient bits 3:0, reset 1000
// [RULE_05] bit 6 picks thermistor or host temperature
// [RULE_06] host temperature bits 5:0, reset 11011
// [RULE_07] charge percent read-only, 0 to 100
// [RULE_08] voltage 12:5 high, 4:0 low bits 7:3
// [RULE_09] software computes high*32 plus low/8
// [RULE_10] reset bit 7 clears charge and voltage
// [RULE_11] unused bits zero, read-only writes ignored
// [RULE_12] voltage halves always updated together
module fgp_regs
  import fgp_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // host register access
  input wire fgp_req_t hostReq,
  output logic [7:0] hostRdata,
  output logic hostRvalid,
  // measurement results from the gauge core
  input wire fgp_meas_t measIn,
  // temperature sources
  input wire logic [5:0] thermistorInput,
  // parameters to the gauge core
  output fgp_param_t paramOut,
  output logic [5:0] selectedTemp
);

  // index into the resistance table, 7 when not a table address
  function automatic logic [2:0] resIdx(input logic [7:0] a);
    if (a >= ADDR_CELL_RES_0C && a <= ADDR_CELL_RES_60C) begin
      resIdx = 3'(a - ADDR_CELL_RES_0C);
    end else begin
      resIdx = 3'h7;
    end
  endfunction

  // all module state in one struct
  typedef struct packed {
    logic [1:0] lowChargeCoeff;
    logic [3:0] chargingCoeff;
    logic tempSource;
    logic [5:0] hostTemp;
    logic [6:0] chargePct;
    logic [12:0] voltage;
    logic rdPend;
    logic tblRd;
    logic [7:0] rdLocal;
    logic [7:0] rdata;
    logic rvalid;
    logic [5:0] selTemp;
  } fgp_state_t;

  fgp_state_t st_q, st_d;
  logic [7:0] tblData; // registered table read
  logic [5:0][7:0] tblAll; // every resistance entry
  logic tblWr; // write hits the table
  logic socClear; // reset register bit 7 written

  assign tblWr = hostReq.wrEn && (resIdx(hostReq.addr) != 3'h7);
  assign socClear = hostReq.wrEn && hostReq.addr == ADDR_SOC_RESET && hostReq.wdata[POS_SOC_RESET];

  // resistance table, codes are 32 milliohm steps
  fgp_res_mem u_mem (
    .core_clk(core_clk),
    .srst(srst),
    .wrEn(tblWr), // [RULE_01]
    .wrIdx(resIdx(hostReq.addr)),
    .wrData(hostReq.wdata),
    .rdIdx(resIdx(hostReq.addr)),
    .rdData(tblData),
    .allEntries(tblAll)
  );

  // next state: host writes, measurements, read path
  always_comb begin
    st_d = st_q;
    // writable fields only; other bits of the byte are dropped
    if (hostReq.wrEn && hostReq.addr == ADDR_RES_COEFF) begin
      st_d.lowChargeCoeff = hostReq.wdata[POS_LOW_CHARGE_COEFF +: 2]; // [RULE_03]
      st_d.chargingCoeff = hostReq.wdata[POS_CHARGING_COEFF +: 4]; // [RULE_04]
    end
    if (hostReq.wrEn && hostReq.addr == ADDR_TEMP_CTRL) begin
      st_d.tempSource = hostReq.wdata[POS_TEMP_SOURCE]; // [RULE_05]
      st_d.hostTemp = hostReq.wdata[POS_HOST_TEMP +: 6]; // [RULE_06]
    end
    // measurement: both voltage halves from one sample
    if (measIn.valid) begin
      st_d.voltage = measIn.voltage; // [RULE_12]
      // clamp keeps the percent inside 0..100
      st_d.chargePct = (measIn.chargePct > MAX_CHARGE_PCT) ? MAX_CHARGE_PCT : measIn.chargePct; // [RULE_07]
    end
    // clear wins over a same-cycle sample, so a reset is never undone
    if (socClear) begin
      st_d.chargePct = 7'h00; // [RULE_10]
      st_d.voltage = 13'h0000; // [RULE_10]
    end
    // temperature source mux
    st_d.selTemp = st_q.tempSource ? st_q.hostTemp : thermistorInput; // [RULE_05]
    // read stage 1: capture local value; stage 2 merges table data
    st_d.rdPend = hostReq.rdEn;
    st_d.tblRd = hostReq.rdEn && (resIdx(hostReq.addr) != 3'h7);
    case (hostReq.addr)
      ADDR_RES_COEFF: st_d.rdLocal = {2'b00, st_q.lowChargeCoeff, st_q.chargingCoeff}; // [RULE_11]
      ADDR_TEMP_CTRL: st_d.rdLocal = {1'b0, st_q.tempSource, st_q.hostTemp}; // [RULE_11]
      ADDR_CHARGE_PCT: st_d.rdLocal = {1'b0, st_q.chargePct}; // [RULE_07]
      ADDR_VOLT_HIGH: st_d.rdLocal = st_q.voltage[12:5]; // [RULE_08]
      ADDR_VOLT_LOW: st_d.rdLocal = {st_q.voltage[4:0], 3'b000}; // [RULE_08]
      default: st_d.rdLocal = 8'h00; // [RULE_11]
    endcase
    st_d.rvalid = st_q.rdPend;
    st_d.rdata = st_q.tblRd ? tblData : st_q.rdLocal;
  end

  // register all state
  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_q <= '0;
      st_q.lowChargeCoeff <= RST_LOW_CHARGE_COEFF; // [RULE_03]
      st_q.chargingCoeff <= RST_CHARGING_COEFF; // [RULE_04]
      st_q.tempSource <= RST_TEMP_SOURCE; // [RULE_05]
      st_q.hostTemp <= RST_HOST_TEMP; // [RULE_06]
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from flip-flops
  assign hostRdata = st_q.rdata;
  assign hostRvalid = st_q.rvalid;
  assign selectedTemp = st_q.selTemp;
  assign paramOut.cellRes = tblAll;
  assign paramOut.lowChargeCoeff = st_q.lowChargeCoeff;
  assign paramOut.chargingCoeff = st_q.chargingCoeff;
  assign paramOut.tempSourceSelect = st_q.tempSource;
  assign paramOut.hostTempValue = st_q.hostTemp;

endmodule // fgp_regs

// *** hw/fgp_pkg.sv ***
package fgp_pkg;

  // register offsets on the serial register port
  localparam logic [7:0] ADDR_CELL_RES_0C = 8'h19;
  localparam logic [7:0] ADDR_CELL_RES_10C = 8'h1a;
  localparam logic [7:0] ADDR_CELL_RES_20C = 8'h1b;
  localparam logic [7:0] ADDR_CELL_RES_30C = 8'h1c;
  localparam logic [7:0] ADDR_CELL_RES_40C = 8'h1d;
  localparam logic [7:0] ADDR_CELL_RES_60C = 8'h1e;
  localparam logic [7:0] ADDR_RES_COEFF = 8'h1f;
  localparam logic [7:0] ADDR_TEMP_CTRL = 8'h20;
  localparam logic [7:0] ADDR_CHARGE_PCT = 8'h21;
  localparam logic [7:0] ADDR_VOLT_HIGH = 8'h22;
  localparam logic [7:0] ADDR_VOLT_LOW = 8'h23;
  localparam logic [7:0] ADDR_SOC_RESET = 8'h25;

  // number of cell resistance points
  localparam int NUM_RES = 6;

  // reset values
  localparam logic [7:0] RST_CELL_RES = 8'h3f;
  localparam logic [1:0] RST_LOW_CHARGE_COEFF = 2'h0;
  localparam logic [3:0] RST_CHARGING_COEFF = 4'h8;
  localparam logic RST_TEMP_SOURCE = 1'b0;
  localparam logic [5:0] RST_HOST_TEMP = 6'h1b;

  // field positions
  localparam int POS_LOW_CHARGE_COEFF = 4;
  localparam int POS_CHARGING_COEFF = 0;
  localparam int POS_TEMP_SOURCE = 6;
  localparam int POS_HOST_TEMP = 0;
  localparam int POS_VOLT_LOW = 3;
  localparam int POS_SOC_RESET = 7;

  // state of charge ceiling, percent
  localparam logic [6:0] MAX_CHARGE_PCT = 7'h64;

  // host register access, one cycle strobes
  typedef struct packed {
    logic wrEn;
    logic rdEn;
    logic [7:0] addr;
    logic [7:0] wdata;
  } fgp_req_t;

  // one measurement sample from the gauge core
  typedef struct packed {
    logic valid;
    logic [6:0] chargePct;
    logic [12:0] voltage;
  } fgp_meas_t;

  // parameters driven to the gauge core
  typedef struct packed {
    logic [5:0][7:0] cellRes;
    logic [1:0] lowChargeCoeff;
    logic [3:0] chargingCoeff;
    logic tempSourceSelect;
    logic [5:0] hostTempValue;
  } fgp_param_t;

endpackage

// *** hw/fgp_res_mem.sv ***
`timescale 1ns/1ps
// six-entry resistance table; read data registered
module fgp_res_mem
  import fgp_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // write port
  input wire logic wrEn,
  input wire logic [2:0] wrIdx,
  input wire logic [7:0] wrData,
  // registered read port
  input wire logic [2:0] rdIdx,
  output logic [7:0] rdData,
  // all entries for the gauge core
  output logic [5:0][7:0] allEntries
);

  // all module state in one struct
  typedef struct packed {
    logic [5:0][7:0] mem;
    logic [7:0] rd;
  } fgp_mem_state_t;

  fgp_mem_state_t st_q, st_d;

  // next state: write one entry, register read data
  always_comb begin
    st_d = st_q;
    for (int i = 0; i < NUM_RES; i++) begin
      if (wrEn && wrIdx == 3'(i)) begin
        st_d.mem[i] = wrData; // [RULE_02]
      end
    end
    // out of range index reads zero
    st_d.rd = (rdIdx < 3'(NUM_RES)) ? st_q.mem[rdIdx] : 8'h00;
  end

  // register, every entry resets to 0x3f
  always_ff @(posedge core_clk) begin
    if (srst) begin
      for (int i = 0; i < NUM_RES; i++) begin
        st_q.mem[i] <= RST_CELL_RES; // [RULE_02]
      end
      st_q.rd <= 8'h00;
    end else begin
      st_q <= st_d;
    end
  end

  assign rdData = st_q.rd;
  assign allEntries = st_q.mem;

endmodule // fgp_res_mem

// *** verification/fgp_regs_properties.sv ***
`timescale 1ns/1ps
// port-level checks of the register bank
module fgp_regs_properties
  import fgp_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // host port
  input wire fgp_req_t hostReq,
  input wire logic [7:0] hostRdata,
  input wire logic hostRvalid,
  // gauge side
  input wire fgp_meas_t measIn,
  input wire logic [5:0] thermistorInput,
  input wire fgp_param_t paramOut,
  input wire logic [5:0] selectedTemp
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  // temperature that the mux should pick; $past needs a plain signal
  logic [5:0] pick;
  assign pick = paramOut.tempSourceSelect ? paramOut.hostTempValue : thermistorInput;
  rd_latency_a: assert property (hostReq.rdEn |-> ##2 hostRvalid) else $error("late read");
  res_write_a: assert property (hostReq.wrEn && hostReq.addr inside {[8'h19:8'h1e]} |=>
    paramOut.cellRes[$past(hostReq.addr) - 8'h19] == $past(hostReq.wdata)) else $error("bad res");
  coeff_write_a: assert property (hostReq.wrEn && hostReq.addr == ADDR_RES_COEFF |=>
    {paramOut.lowChargeCoeff, paramOut.chargingCoeff} == $past(hostReq.wdata[5:0])) else $error("bad coeff");
  temp_write_a: assert property (hostReq.wrEn && hostReq.addr == ADDR_TEMP_CTRL |=>
    {paramOut.tempSourceSelect, paramOut.hostTempValue} == $past(hostReq.wdata[6:0])) else $error("bad temp");
  temp_mux_a: assert property (!$past(srst) |-> selectedTemp == $past(pick)) else $error("bad pick");
  pct_limit_a: assert property (hostRvalid && $past(hostReq.addr, 2) == ADDR_CHARGE_PCT |->
    hostRdata <= 8'h64) else $error("pct range");
  low_unused_a: assert property (hostRvalid && $past(hostReq.addr, 2) == ADDR_VOLT_LOW |->
    hostRdata[2:0] == 3'h0) else $error("low bits");
  unmapped_zero_a: assert property (hostRvalid && $past(hostReq.addr, 2) > ADDR_SOC_RESET |->
    hostRdata == 8'h00) else $error("unmapped");
  param_hold_a: assert property (!hostReq.wrEn |=> $stable(paramOut)) else $error("param moved");
  cover property (hostReq.wrEn && hostReq.addr == ADDR_SOC_RESET && measIn.valid);
  cover property (measIn.valid && measIn.chargePct > MAX_CHARGE_PCT);
  cover property (hostRvalid && hostRdata == 8'h64);
endmodule // fgp_regs_properties
bind fgp_regs fgp_regs_properties i_fgp_regs_properties (.core_clk(core_clk), .srst(srst), .hostReq(hostReq),
  .hostRdata(hostRdata), .hostRvalid(hostRvalid), .measIn(measIn), .thermistorInput(thermistorInput),
  .paramOut(paramOut), .selectedTemp(selectedTemp));

// *** verification/fgp_host_model.sv ***
`timescale 1ns/1ps
// host controller on the register port
module fgp_host_model
  import fgp_pkg::*;
(
  // clock
  input wire logic core_clk,
  // register port
  output fgp_req_t hostReq,
  input wire logic [7:0] hostRdata,
  input wire logic hostRvalid
);
  initial hostReq = '0;
  // one-cycle strobe; released address and data are inverted so stale values never match
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    hostReq <= '{wrEn: 1'b1, rdEn: 1'b0, addr: a, wdata: d};
    @(posedge core_clk);
    hostReq <= '{wrEn: 1'b0, rdEn: 1'b0, addr: ~a, wdata: ~d};
  endtask
  // read; a missing answer returns unknown so the caller's compare fails
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    hostReq <= '{wrEn: 1'b0, rdEn: 1'b1, addr: a, wdata: 8'h00};
    @(posedge core_clk);
    hostReq <= '{wrEn: 1'b0, rdEn: 1'b0, addr: ~a, wdata: 8'hff};
    for (int i = 0; i < 3 && hostRvalid !== 1'b1; i++) @(posedge core_clk);
    d = (hostRvalid === 1'b1) ? hostRdata : 8'hxx;
  endtask
  // millivolts from the two readout bytes
  function automatic int mv(input logic [7:0] h, input logic [7:0] l);
    return h * 32 + l / 8;
  endfunction
endmodule // fgp_host_model

// *** verification/tb_top.sv ***
`timescale 1ns/1ps
// host model on the port, gauge core played here
module tb_top;
  import fgp_pkg::*;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  fgp_req_t hostReq;
  logic [7:0] hostRdata;
  logic hostRvalid;
  fgp_meas_t measIn = '0;
  logic [5:0] thermistorInput = 6'h00;
  fgp_param_t paramOut;
  logic [5:0] selectedTemp;
  int errCount = 0;
  int comparisons = 0;
  logic [7:0] rv;
  logic [7:0] rh;
  logic [7:0] want; // expected byte, kept apart to keep compare lines short
  always #5 core_clk = ~core_clk;
  fgp_regs i_fgp_regs (.core_clk(core_clk), .srst(srst), .hostReq(hostReq), .hostRdata(hostRdata),
    .hostRvalid(hostRvalid), .measIn(measIn), .thermistorInput(thermistorInput), .paramOut(paramOut),
    .selectedTemp(selectedTemp));
  fgp_host_model i_host (.core_clk(core_clk), .hostReq(hostReq), .hostRdata(hostRdata), .hostRvalid(hostRvalid));
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      errCount++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic completeRun();
    if (errCount == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // reset image of every place, unmapped ones included
  task automatic testReset();
    for (int a = 8'h19; a <= 8'h26; a++) begin
      i_host.rd(8'(a), rv);
      want = a < 8'h1f ? 8'h3f : a == 8'h1f ? 8'h08 : a == 8'h20 ? 8'h1b : 8'h00;
      cmp(rv, want);
    end
  endtask
  // writes everywhere, one idle cycle apart, data keyed to address to expose decode slips
  task automatic testWrite(input logic [7:0] d);
    for (int a = 8'h19; a <= 8'h26; a++) i_host.wr(8'(a), d ^ 8'(a));
    for (int a = 8'h19; a <= 8'h26; a++) begin
      i_host.rd(8'(a), rv);
      want = (d ^ 8'(a)) & (a < 8'h1f ? 8'hff : a == 8'h1f ? 8'h3f : a == 8'h20 ? 8'h7f : 8'h00);
      cmp(rv, want);
      if (a < 8'h1f) cmp(paramOut.cellRes[a - 8'h19], d ^ 8'(a));
    end
    cmp({2'h0, paramOut.lowChargeCoeff, paramOut.chargingCoeff}, (d ^ 8'h1f) & 8'h3f);
  endtask
  // over-range sample, then a clear racing a new sample at the same edge
  task automatic testMeas();
    @(posedge core_clk);
    measIn <= '{valid: 1'b1, chargePct: 7'h7f, voltage: 13'h1abc};
    @(posedge core_clk);
    measIn.valid <= 1'b0;
    i_host.rd(ADDR_CHARGE_PCT, rv);
    cmp(rv, 8'h64);
    i_host.rd(ADDR_VOLT_HIGH, rh);
    i_host.rd(ADDR_VOLT_LOW, rv);
    cmp(rh, 8'hd5);
    cmp(rv, 8'he0);
    cmp(8'(i_host.mv(rh, rv) == 6844), 8'h01);
    fork
      i_host.wr(ADDR_SOC_RESET, 8'h80);
      begin
        @(posedge core_clk);
        measIn <= '{valid: 1'b1, chargePct: 7'h32, voltage: 13'h0fff};
        @(posedge core_clk);
        measIn.valid <= 1'b0;
      end
    join
    for (int a = 8'h21; a <= 8'h23; a++) begin
      i_host.rd(8'(a), rv);
      cmp(rv, 8'h00);
    end
    // in-range sample passes unclamped, both voltage halves follow it
    @(posedge core_clk);
    measIn <= '{valid: 1'b1, chargePct: 7'h32, voltage: 13'h0fff};
    @(posedge core_clk);
    measIn.valid <= 1'b0;
    i_host.rd(ADDR_CHARGE_PCT, rv);
    cmp(rv, 8'h32);
    i_host.rd(ADDR_VOLT_HIGH, rh);
    i_host.rd(ADDR_VOLT_LOW, rv);
    cmp(rh, 8'h7f);
    cmp(rv, 8'hf8);
  endtask
  // thermistor first, then the host value
  task automatic testTemp();
    thermistorInput <= 6'h2a;
    i_host.wr(ADDR_TEMP_CTRL, 8'h05);
    repeat (2) @(posedge core_clk);
    cmp({2'h0, selectedTemp}, 8'h2a);
    i_host.wr(ADDR_TEMP_CTRL, 8'h45);
    repeat (2) @(posedge core_clk);
    cmp({2'h0, selectedTemp}, 8'h05);
  endtask
  initial begin
    repeat (20) @(posedge core_clk);
    srst <= 1'b0;
    testReset();
    testWrite(8'hff);
    testWrite(8'h00);
    testMeas();
    testTemp();
    completeRun();
  end
  // hang guard, far beyond the few hundred cycles needed
  initial begin
    repeat (5000) @(posedge core_clk);
    errCount++;
    completeRun();
  end
endmodule // tb_top
